// file: logic/bist_reset_wakeup_regs.sv
/*
 Self-test status, soft reset control and wake-up detection registers,
 with the pattern-0 CRC match, pattern gating and an interrupt.
 Assumes a classic Wishbone master on one 25 MHz clock; the queue manager,
 the pattern matchers for patterns 1-3 and the magic packet matcher sit
 outside and report one-cycle match pulses.
*/
// Local design decision: the Wishbone register port.
// How it works
// - Read-only status shows both buffer self-test results
// - Bit 12 set when transmit test completes
// - Bit 11 set when transmit test fails
// - Bits 10:8 count transmit test failures
// - Bit 4 set when receive test completes
// - Bit 3 set when receive test fails
// - Bits 2:0 count receive test failures
// - Bit 1 holds queue manager reset active
// - Queue reset flushes packets and queue registers
// - Bit 0 holds whole-device reset, registers default
// - Bit 7 gates magic packet detection
// - Wake bits 3:0 enable patterns individually
// - Pattern compares masked-byte Ethernet CRC to expected
// - Pattern 0 expected CRC split low/high halves
// - Mask bit 0 byte one, bit 15 byte sixteen
`timescale 1ns/1ps
module bist_reset_wakeup_regs
   import bist_wake_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [ADDR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic [BIST_DW-1:0] tx_fault_xor_in,
   input wire logic [BIST_DW-1:0] rx_fault_xor_in,
   input wire logic frame_start_in,
   input wire logic frame_byte_valid_in,
   input wire logic [7:0] frame_byte_in,
   input wire logic frame_end_in,
   input wire logic magic_match_in,
   input wire logic [PATTERNS-1:1] pattern_match_in,
   output logic queue_manager_reset_out,
   output logic global_soft_reset_out,
   output logic magic_packet_detect_en_out,
   output logic [PATTERNS-1:0] wake_pattern_en_out,
   output logic [31:0] wake_pattern0_crc_out,
   output logic [15:0] wake_pattern0_mask_word0_out,
   output logic [PATTERNS-1:0] wake_match_out,
   output logic magic_wake_out,
   output logic irq_out
);
   logic ack_q;
   logic [15:0] rdata_d;
   logic [31:0] rdata_q;
   logic [IDX_W-1:0] idx_w;
   logic req_w;
   logic wr_w;
   logic [15:0] lane_w;
   logic [15:0] soft_reset_q;
   logic [15:0] wake_ctrl_q;
   logic [15:0] crc_low_q;
   logic [15:0] crc_high_q;
   logic [15:0] mask_word0_q;
   logic [INT_W-1:0] int_status_q;
   logic [INT_W-1:0] int_mask_q;
   logic [INT_W-1:0] int_event_w;
   logic block_reset_w;
   logic bist_restart_w;
   logic tx_done_w;
   logic tx_failed_w;
   logic [COUNT_W-1:0] tx_count_w;
   logic rx_done_w;
   logic rx_failed_w;
   logic [COUNT_W-1:0] rx_count_w;
   logic tx_done_q;
   logic rx_done_q;
   logic pattern0_match_w;
   logic [PATTERNS-1:0] match_d;
   logic magic_d;

   // Merge a 16-bit write through the two low byte lanes
   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] din,
      input logic [3:0] sel,
      input logic [15:0] writable
   );
      logic [15:0] m;
      m = old;
      if (sel[0]) begin
         m[7:0] = din[7:0];
      end
      if (sel[1]) begin
         m[15:8] = din[15:8];
      end
      merge16 = (m & writable) | (old & ~writable);
   endfunction

   function automatic logic hit(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] b);
      hit = (a == b);
   endfunction

   // Register index sits above the byte offset within the word
   assign idx_w = wb_adr_in[ADDR_W-1:2];
   assign req_w = wb_cyc_in && wb_stb_in && !ack_q;
   assign wr_w = req_w && wb_we_in;
   assign lane_w = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

   // Global soft reset holds this group's other registers at default
   // while the bit stays set; the bit itself survives so software can
   // release it
   assign block_reset_w = reset_in || soft_reset_q[GLOBAL_RESET_BIT];
   assign bist_restart_w = soft_reset_q[GLOBAL_RESET_BIT];

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req_w;
      end
   end

   assign wb_ack_out = ack_q;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         soft_reset_q <= REG_RESET;
      end else if (wr_w && hit(idx_w, IDX_SOFT_RESET)) begin
         soft_reset_q <= merge16(soft_reset_q, wb_dat_in, wb_sel_in, SOFT_RESET_MASK);
      end
   end

   always_ff @(posedge clk_in) begin
      if (block_reset_w) begin
         wake_ctrl_q <= REG_RESET;
      end else if (wr_w && hit(idx_w, IDX_WAKE_CTRL)) begin
         wake_ctrl_q <= merge16(wake_ctrl_q, wb_dat_in, wb_sel_in, WAKE_CTRL_MASK);
      end
   end

   always_ff @(posedge clk_in) begin
      if (block_reset_w) begin
         crc_low_q <= REG_RESET;
         crc_high_q <= REG_RESET;
      end else if (wr_w) begin
         if (hit(idx_w, IDX_CRC_LOW)) begin
            crc_low_q <= merge16(crc_low_q, wb_dat_in, wb_sel_in, 16'hFFFF);
         end
         if (hit(idx_w, IDX_CRC_HIGH)) begin
            crc_high_q <= merge16(crc_high_q, wb_dat_in, wb_sel_in, 16'hFFFF);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (block_reset_w) begin
         mask_word0_q <= REG_RESET;
      end else if (wr_w && hit(idx_w, IDX_MASK_WORD0)) begin
         mask_word0_q <= merge16(mask_word0_q, wb_dat_in, wb_sel_in, 16'hFFFF);
      end
   end

   always_ff @(posedge clk_in) begin
      if (block_reset_w) begin
         int_mask_q <= INT_RESET;
      end else if (wr_w && hit(idx_w, IDX_INT_MASK)) begin
         int_mask_q <= INT_W'(merge16({9'h000, int_mask_q}, wb_dat_in, wb_sel_in, 16'h007F));
      end
   end

   // Both buffer memories are tested after hardware or global reset
   mem_selftest tx_selftest (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .restart_in(bist_restart_w),
      .fault_xor_in(tx_fault_xor_in),
      .done_out(tx_done_w),
      .failed_out(tx_failed_w),
      .fail_count_out(tx_count_w)
   );

   mem_selftest rx_selftest (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .restart_in(bist_restart_w),
      .fault_xor_in(rx_fault_xor_in),
      .done_out(rx_done_w),
      .failed_out(rx_failed_w),
      .fail_count_out(rx_count_w)
   );

   wake_crc_match pattern0_match (
      .clk_in(clk_in),
      .reset_in(block_reset_w),
      .enable_in(wake_ctrl_q[0]),
      .byte_mask_in(mask_word0_q),
      .expected_crc_in({crc_high_q, crc_low_q}),
      .frame_start_in(frame_start_in),
      .byte_valid_in(frame_byte_valid_in),
      .byte_in(frame_byte_in),
      .frame_end_in(frame_end_in),
      .match_out(pattern0_match_w)
   );

   // Outside matchers only count while their enable bit is set
   always_comb begin
      match_d = {pattern_match_in & wake_ctrl_q[PATTERNS-1:1], pattern0_match_w};
      magic_d = magic_match_in && wake_ctrl_q[MAGIC_EN_BIT];
   end

   always_ff @(posedge clk_in) begin
      if (block_reset_w) begin
         wake_match_out <= '0;
         magic_wake_out <= 1'b0;
      end else begin
         wake_match_out <= match_d;
         magic_wake_out <= magic_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tx_done_q <= 1'b0;
         rx_done_q <= 1'b0;
      end else begin
         tx_done_q <= tx_done_w;
         rx_done_q <= rx_done_w;
      end
   end

   always_comb begin
      int_event_w = '0;
      int_event_w[INT_TX_DONE] = tx_done_w && !tx_done_q;
      int_event_w[INT_RX_DONE] = rx_done_w && !rx_done_q;
      int_event_w[INT_MAGIC] = magic_wake_out;
      int_event_w[INT_PATTERN_LSB +: PATTERNS] = wake_match_out;
   end

   // A new event in the clearing cycle keeps its bit set
   always_ff @(posedge clk_in) begin
      if (block_reset_w) begin
         int_status_q <= INT_RESET;
      end else if (wr_w && hit(idx_w, IDX_INT_STATUS)) begin
         int_status_q <= (int_status_q & ~(wb_dat_in[INT_W-1:0] & lane_w[INT_W-1:0])) | int_event_w;
      end else begin
         int_status_q <= int_status_q | int_event_w;
      end
   end

   assign irq_out = |(int_status_q & int_mask_q);

   // Read data is registered with the acknowledge; unmapped reads give zero
   always_comb begin
      rdata_d = 16'h0000;
      case (idx_w)
         IDX_SELFTEST: begin
            rdata_d[TX_DONE_BIT] = tx_done_w;
            rdata_d[TX_FAIL_BIT] = tx_failed_w;
            rdata_d[TX_COUNT_LSB +: COUNT_W] = tx_count_w;
            rdata_d[RX_DONE_BIT] = rx_done_w;
            rdata_d[RX_FAIL_BIT] = rx_failed_w;
            rdata_d[RX_COUNT_LSB +: COUNT_W] = rx_count_w;
         end
         IDX_SOFT_RESET: rdata_d = soft_reset_q;
         IDX_WAKE_CTRL: rdata_d = wake_ctrl_q;
         IDX_CRC_LOW: rdata_d = crc_low_q;
         IDX_CRC_HIGH: rdata_d = crc_high_q;
         IDX_MASK_WORD0: rdata_d = mask_word0_q;
         IDX_INT_STATUS: rdata_d = {9'h000, int_status_q};
         IDX_INT_MASK: rdata_d = {9'h000, int_mask_q};
         default: rdata_d = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rdata_q <= 32'h00000000;
      end else if (req_w && !wb_we_in) begin
         rdata_q <= {16'h0000, rdata_d};
      end
   end

   assign wb_dat_out = rdata_q;

   // Queue manager flush is held for as long as the bit stays set; the
   // queue manager clears its memories and registers on this level
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         queue_manager_reset_out <= 1'b0;
         global_soft_reset_out <= 1'b0;
      end else begin
         queue_manager_reset_out <= soft_reset_q[QM_RESET_BIT] || soft_reset_q[GLOBAL_RESET_BIT];
         global_soft_reset_out <= soft_reset_q[GLOBAL_RESET_BIT];
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         magic_packet_detect_en_out <= 1'b0;
         wake_pattern_en_out <= '0;
         wake_pattern0_crc_out <= 32'h00000000;
         wake_pattern0_mask_word0_out <= 16'h0000;
      end else begin
         magic_packet_detect_en_out <= wake_ctrl_q[MAGIC_EN_BIT];
         wake_pattern_en_out <= wake_ctrl_q[PATTERNS-1:0];
         wake_pattern0_crc_out <= {crc_high_q, crc_low_q};
         wake_pattern0_mask_word0_out <= mask_word0_q;
      end
   end
endmodule

// file: inc/bist_wake_pkg.sv
/*
 Constants for the self-test, soft reset and wake-up control register group.
 Assumes a 32-bit classic Wishbone slave; each register index is a word.
*/
package bist_wake_pkg;
   localparam int ADDR_W = 10;
   localparam int IDX_W = 8;
   localparam logic [IDX_W-1:0] IDX_SELFTEST = 8'h24;
   localparam logic [IDX_W-1:0] IDX_SOFT_RESET = 8'h26;
   localparam logic [IDX_W-1:0] IDX_WAKE_CTRL = 8'h2A;
   localparam logic [IDX_W-1:0] IDX_CRC_LOW = 8'h30;
   localparam logic [IDX_W-1:0] IDX_CRC_HIGH = 8'h32;
   localparam logic [IDX_W-1:0] IDX_MASK_WORD0 = 8'h34;
   localparam logic [IDX_W-1:0] IDX_INT_STATUS = 8'h3C;
   localparam logic [IDX_W-1:0] IDX_INT_MASK = 8'h3E;
   localparam int TX_DONE_BIT = 12;
   localparam int TX_FAIL_BIT = 11;
   localparam int TX_COUNT_LSB = 8;
   localparam int RX_DONE_BIT = 4;
   localparam int RX_FAIL_BIT = 3;
   localparam int RX_COUNT_LSB = 0;
   localparam int COUNT_W = 3;
   localparam int QM_RESET_BIT = 1;
   localparam int GLOBAL_RESET_BIT = 0;
   localparam int MAGIC_EN_BIT = 7;
   localparam int PATTERNS = 4;
   localparam int INT_TX_DONE = 0;
   localparam int INT_RX_DONE = 1;
   localparam int INT_MAGIC = 2;
   localparam int INT_PATTERN_LSB = 3;
   localparam int INT_W = 7;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [INT_W-1:0] INT_RESET = 7'h00;
   localparam logic [15:0] WAKE_CTRL_MASK = 16'h008F;
   localparam logic [15:0] SOFT_RESET_MASK = 16'h0003;
   localparam int BIST_DEPTH = 16;
   localparam int BIST_AW = 4;
   localparam int BIST_DW = 8;
   localparam logic [BIST_DW-1:0] BIST_PATTERN = 8'hA5;
   localparam int MASK_BYTES = 16;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_FINAL_XOR = 32'hFFFFFFFF;
   localparam logic [7:0] FRAME_INDEX_MAX = 8'hFF;
   typedef enum logic [1:0] {
      BIST_IDLE = 2'b00,
      BIST_WRITE = 2'b01,
      BIST_READ = 2'b11,
      BIST_DONE = 2'b10
   } bist_state_e;
endpackage

// file: logic/mem_selftest.sv
/*
 Write-then-read self-test over a small buffer memory array.
 Assumes restart_in is a level that restarts the test while high.
*/
`timescale 1ns/1ps
module mem_selftest
   import bist_wake_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic restart_in,
   input wire logic [BIST_DW-1:0] fault_xor_in,
   output logic done_out,
   output logic failed_out,
   output logic [COUNT_W-1:0] fail_count_out
);
   logic [BIST_DW-1:0] mem_q [BIST_DEPTH];
   bist_state_e state_q;
   logic [BIST_AW-1:0] addr_q;
   logic [BIST_DW-1:0] expect_w;

   function automatic logic [COUNT_W-1:0] sat_inc(input logic [COUNT_W-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction

   assign expect_w = BIST_PATTERN ^ {{(BIST_DW-BIST_AW){1'b0}}, addr_q};

   always_ff @(posedge clk_in) begin
      if (state_q == BIST_WRITE) begin
         mem_q[addr_q] <= expect_w ^ fault_xor_in;
      end
   end

   // Results hold from completion until the next restart
   always_ff @(posedge clk_in) begin
      if (reset_in || restart_in) begin
         state_q <= BIST_IDLE;
         addr_q <= '0;
         done_out <= 1'b0;
         failed_out <= 1'b0;
         fail_count_out <= '0;
      end else begin
         case (state_q)
            BIST_IDLE: state_q <= BIST_WRITE;
            BIST_WRITE: begin
               addr_q <= addr_q + 1'b1;
               if (&addr_q) begin
                  state_q <= BIST_READ;
               end
            end
            BIST_READ: begin
               addr_q <= addr_q + 1'b1;
               if (mem_q[addr_q] != expect_w) begin
                  failed_out <= 1'b1;
                  fail_count_out <= sat_inc(fail_count_out);
               end
               if (&addr_q) begin
                  state_q <= BIST_DONE;
                  done_out <= 1'b1;
               end
            end
            BIST_DONE: state_q <= BIST_DONE;
            default: state_q <= BIST_IDLE;
         endcase
      end
   end
endmodule

// file: logic/wake_crc_match.sv
/*
 Masked Ethernet CRC check of one wake-up pattern over the first mask word.
 Assumes one frame byte per valid pulse, framed by start and end pulses.
*/
`timescale 1ns/1ps
module wake_crc_match
   import bist_wake_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic enable_in,
   input wire logic [15:0] byte_mask_in,
   input wire logic [31:0] expected_crc_in,
   input wire logic frame_start_in,
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   input wire logic frame_end_in,
   output logic match_out
);
   logic [31:0] crc_q;
   logic [7:0] index_q;
   logic selected_w;

   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      crc_byte = r;
   endfunction

   // Mask bit n picks frame byte n+1; later bytes are outside this word
   assign selected_w = (index_q < 8'(MASK_BYTES)) && byte_mask_in[index_q[3:0]];

   always_ff @(posedge clk_in) begin
      if (reset_in || frame_start_in) begin
         crc_q <= CRC_INIT;
         index_q <= '0;
      end else if (byte_valid_in) begin
         if (selected_w) begin
            crc_q <= crc_byte(crc_q, byte_in);
         end
         if (index_q != FRAME_INDEX_MAX) begin
            index_q <= index_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         match_out <= 1'b0;
      end else begin
         match_out <= frame_end_in && enable_in && ((crc_q ^ CRC_FINAL_XOR) == expected_crc_in);
      end
   end
endmodule

// file: testbench/bist_reset_wakeup_regs_sva.sv
/*
 Port checker bound into the register group; one clock domain.
*/
`timescale 1ns/1ps
module bist_regs_checker
   import bist_wake_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [ADDR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic magic_match_in,
   input wire logic [PATTERNS-1:1] pattern_match_in,
   input wire logic queue_manager_reset_out,
   input wire logic global_soft_reset_out,
   input wire logic magic_packet_detect_en_out,
   input wire logic [PATTERNS-1:0] wake_pattern_en_out,
   input wire logic [31:0] wake_pattern0_crc_out,
   input wire logic [15:0] wake_pattern0_mask_word0_out,
   input wire logic [PATTERNS-1:0] wake_match_out,
   input wire logic magic_wake_out
);
   logic take_q;
   logic we_q;
   logic [1:0] sel_q;
   logic [IDX_W-1:0] idx_q;
   logic [15:0] dat_q;
   logic wr_w;
   assign wr_w = take_q && we_q && sel_q == 2'b11 && !global_soft_reset_out;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   always_ff @(posedge clk_in) begin
      take_q <= wb_cyc_in && wb_stb_in && !wb_ack_out;
      we_q <= wb_we_in;
      sel_q <= wb_sel_in[1:0];
      idx_q <= wb_adr_in[9:2];
      dat_q <= wb_dat_in[15:0];
   end
   a_ack_follows_req: assert property (take_q |-> wb_ack_out)
      else $error("no ack");
   a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack too long");
   a_global_forces_qm: assert property (global_soft_reset_out |-> queue_manager_reset_out)
      else $error("queue reset missing");
   a_magic_gated: assert property (magic_wake_out == ($past(magic_match_in) && magic_packet_detect_en_out))
      else $error("magic not gated");
   a_pattern_gated: assert property (wake_match_out[3:1] == ($past(pattern_match_in) & wake_pattern_en_out[3:1]))
      else $error("pattern not gated");
   a_pattern0_enabled: assert property (wake_match_out[0] |-> wake_pattern_en_out[0])
      else $error("pattern0 disabled");
   a_status_reserved: assert property (take_q && !we_q && idx_q == IDX_SELFTEST
      |-> wb_dat_out[15:13] == 3'h0 && wb_dat_out[7:5] == 3'h0)
      else $error("selftest reserved");
   a_wake_reserved: assert property (take_q && !we_q && idx_q == IDX_WAKE_CTRL
      |-> (wb_dat_out[15:0] & ~WAKE_CTRL_MASK) == 16'h0000)
      else $error("wake reserved");
   a_crc_low_write: assert property (wr_w && idx_q == IDX_CRC_LOW
      |=> wake_pattern0_crc_out[15:0] == $past(dat_q))
      else $error("crc low write");
   a_crc_high_write: assert property (wr_w && idx_q == IDX_CRC_HIGH
      |=> wake_pattern0_crc_out[31:16] == $past(dat_q))
      else $error("crc high write");
   a_mask_word_write: assert property (wr_w && idx_q == IDX_MASK_WORD0
      |=> wake_pattern0_mask_word0_out == $past(dat_q))
      else $error("mask write");
endmodule

bind bist_reset_wakeup_regs bist_regs_checker bist_regs_checker_i (
   .clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
   .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .magic_match_in(magic_match_in), .pattern_match_in(pattern_match_in),
   .queue_manager_reset_out(queue_manager_reset_out), .global_soft_reset_out(global_soft_reset_out),
   .magic_packet_detect_en_out(magic_packet_detect_en_out), .wake_pattern_en_out(wake_pattern_en_out),
   .wake_pattern0_crc_out(wake_pattern0_crc_out), .wake_pattern0_mask_word0_out(wake_pattern0_mask_word0_out),
   .wake_match_out(wake_match_out), .magic_wake_out(magic_wake_out)
);

// file: testbench/tb_top.sv
/*
 Self-checking bench for the register group; needs the checker file.
*/
`timescale 1ns/1ps
module tb_top
   import bist_wake_pkg::*;
;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
   logic [ADDR_W-1:0] wb_adr_in = '0;
   logic [3:0] wb_sel_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0;
   logic [BIST_DW-1:0] tx_fault_xor_in = 8'h00, rx_fault_xor_in = 8'h00;
   logic frame_start_in = 1'b0, frame_byte_valid_in = 1'b0, frame_end_in = 1'b0, magic_match_in = 1'b0;
   logic [7:0] frame_byte_in = 8'h00;
   logic [PATTERNS-1:1] pattern_match_in = 3'h0;
   logic [31:0] wb_dat_out, wake_pattern0_crc_out;
   logic wb_ack_out, queue_manager_reset_out, global_soft_reset_out, magic_packet_detect_en_out;
   logic [PATTERNS-1:0] wake_pattern_en_out, wake_match_out;
   logic [15:0] wake_pattern0_mask_word0_out;
   logic magic_wake_out, irq_out;
   int num_errors = 0;
   int checks = 0;
   logic [31:0] crc;

   bist_reset_wakeup_regs bist_reset_wakeup_regs_i (
      .clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
      .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
      .wb_ack_out(wb_ack_out), .tx_fault_xor_in(tx_fault_xor_in), .rx_fault_xor_in(rx_fault_xor_in),
      .frame_start_in(frame_start_in), .frame_byte_valid_in(frame_byte_valid_in), .frame_byte_in(frame_byte_in),
      .frame_end_in(frame_end_in), .magic_match_in(magic_match_in), .pattern_match_in(pattern_match_in),
      .queue_manager_reset_out(queue_manager_reset_out), .global_soft_reset_out(global_soft_reset_out),
      .magic_packet_detect_en_out(magic_packet_detect_en_out), .wake_pattern_en_out(wake_pattern_en_out),
      .wake_pattern0_crc_out(wake_pattern0_crc_out), .wake_pattern0_mask_word0_out(wake_pattern0_mask_word0_out),
      .wake_match_out(wake_match_out), .magic_wake_out(magic_wake_out), .irq_out(irq_out)
   );

   always #20 clk_in = ~clk_in;

   task automatic summarize();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Bounded wait for ack
   task automatic bus(input logic we, input logic [7:0] idx, input logic [15:0] d, input logic [3:0] sel,
                      output logic [15:0] q);
      int n = 0;
      @(posedge clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= {idx, 2'b00};
      wb_sel_in <= sel;
      wb_dat_in <= {16'h0000, d};
      do begin
         @(posedge clk_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 20);
      q = wb_dat_out[15:0];
      check("bus ack", {31'h0, wb_ack_out}, 32'h1);
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, idx, d, 4'h3, q);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] idx, input logic [15:0] exp);
      logic [15:0] q;
      bus(1'b0, idx, 16'h0000, 4'h3, q);
      check(name, {16'h0000, q}, {16'h0000, exp});
   endtask

   // Frame byte i is 8'h11 + i
   function automatic logic [31:0] ref_crc(input logic [15:0] m);
      logic [31:0] c;
      c = CRC_INIT;
      for (int k = 0; k < 16; k++) begin
         if (m[k]) begin
            c = c ^ {24'h0, 8'(8'h11 + k)};
            for (int j = 0; j < 8; j++) begin
               c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
            end
         end
      end
      return c ^ CRC_FINAL_XOR;
   endfunction

   task automatic send_frame(input logic exp, input string name);
      @(posedge clk_in);
      frame_start_in <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk_in);
         frame_start_in <= 1'b0;
         frame_byte_valid_in <= 1'b1;
         frame_byte_in <= 8'(8'h11 + i);
      end
      @(posedge clk_in);
      frame_byte_valid_in <= 1'b0;
      frame_end_in <= 1'b1;
      @(posedge clk_in);
      frame_end_in <= 1'b0;
      tick(2);
      check(name, {31'h0, wake_match_out[0]}, {31'h0, exp});
   endtask

   task automatic pulse(input logic [7:0] en);
      wr(IDX_WAKE_CTRL, {8'h00, en});
      @(posedge clk_in);
      magic_match_in <= 1'b1;
      pattern_match_in <= 3'h7;
      @(posedge clk_in);
      magic_match_in <= 1'b0;
      pattern_match_in <= 3'h0;
      @(posedge clk_in);
      check("magic wake", {31'h0, magic_wake_out}, {31'h0, en[7]});
      check("pattern wake", {29'h0, wake_match_out[3:1]}, {29'h0, en[3:1]});
      check("enables", {27'h0, magic_packet_detect_en_out, wake_pattern_en_out}, {27'h0, en[7], en[3:0]});
   endtask

   task automatic t_reset_map();
      logic [7:0] tab [5] = '{IDX_SOFT_RESET, IDX_WAKE_CTRL, IDX_CRC_LOW, IDX_CRC_HIGH, IDX_MASK_WORD0};
      tick(40);
      rd_chk("selftest pass", IDX_SELFTEST, 16'h1010);
      foreach (tab[i]) rd_chk("default", tab[i], 16'h0000);
      wr(IDX_SELFTEST, 16'hFFFF);
      rd_chk("selftest ro", IDX_SELFTEST, 16'h1010);
      wr(8'h28, 16'hFFFF);
      rd_chk("unmapped", 8'h28, 16'h0000);
   endtask

   task automatic t_irq();
      rd_chk("int status", IDX_INT_STATUS, 16'h0003);
      check("irq masked", {31'h0, irq_out}, 32'h0);
      wr(IDX_INT_MASK, 16'h0001);
      tick(1);
      check("irq raised", {31'h0, irq_out}, 32'h1);
      wr(IDX_INT_STATUS, 16'h0001);
      rd_chk("int w1c", IDX_INT_STATUS, 16'h0002);
      check("irq cleared", {31'h0, irq_out}, 32'h0);
      wr(IDX_INT_STATUS, 16'h0002);
      wr(IDX_INT_MASK, 16'h0008);
   endtask

   task automatic t_registers();
      logic [15:0] q;
      wr(IDX_WAKE_CTRL, 16'hFFFF);
      rd_chk("wake reserved", IDX_WAKE_CTRL, 16'h008F);
      bus(1'b1, IDX_CRC_HIGH, 16'hABCD, 4'h1, q);
      rd_chk("crc high lane", IDX_CRC_HIGH, 16'h00CD);
      wr(IDX_CRC_HIGH, 16'h1234);
      wr(IDX_CRC_LOW, 16'h5678);
      wr(IDX_MASK_WORD0, 16'h8001);
      tick(1);
      check("crc out", wake_pattern0_crc_out, 32'h12345678);
      check("mask out", {16'h0000, wake_pattern0_mask_word0_out}, 32'h00008001);
   endtask

   task automatic t_wake_gating();
      logic [7:0] tab [5] = '{8'h00, 8'h8F, 8'h80, 8'h05, 8'h0A};
      foreach (tab[i]) pulse(tab[i]);
   endtask

   task automatic t_frame();
      crc = ref_crc(16'h8001);
      wr(IDX_CRC_LOW, crc[15:0]);
      wr(IDX_CRC_HIGH, crc[31:16]);
      wr(IDX_WAKE_CTRL, 16'h0001);
      send_frame(1'b1, "pattern0 match");
      tick(1);
      check("irq match", {31'h0, irq_out}, 32'h1);
      wr(IDX_INT_STATUS, 16'h0008);
      wr(IDX_MASK_WORD0, 16'h0001);
      send_frame(1'b0, "mask byte16");
      wr(IDX_MASK_WORD0, 16'h8001);
      wr(IDX_CRC_LOW, crc[15:0] ^ 16'h0001);
      send_frame(1'b0, "crc mismatch");
      wr(IDX_CRC_LOW, crc[15:0]);
      wr(IDX_WAKE_CTRL, 16'h0000);
      send_frame(1'b0, "pattern0 off");
   endtask

   task automatic t_soft_reset();
      wr(IDX_SOFT_RESET, 16'h0002);
      tick(1);
      check("queue reset", {30'h0, queue_manager_reset_out, global_soft_reset_out}, 32'h2);
      rd_chk("soft reset rb", IDX_SOFT_RESET, 16'h0002);
      wr(IDX_SOFT_RESET, 16'h0000);
      tick(1);
      check("queue release", {30'h0, queue_manager_reset_out, global_soft_reset_out}, 32'h0);
      tx_fault_xor_in <= 8'h01;
      rx_fault_xor_in <= 8'h80;
      wr(IDX_SOFT_RESET, 16'h0001);
      tick(1);
      check("global reset", {30'h0, queue_manager_reset_out, global_soft_reset_out}, 32'h3);
      rd_chk("crc held", IDX_CRC_LOW, 16'h0000);
      rd_chk("selftest held", IDX_SELFTEST, 16'h0000);
      wr(IDX_SOFT_RESET, 16'h0000);
      tick(40);
      rd_chk("selftest fail", IDX_SELFTEST, 16'h1F1F);
      tick(20);
      rd_chk("selftest stable", IDX_SELFTEST, 16'h1F1F);
   endtask

   initial begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      summarize();
   end

   initial begin
      repeat (12) @(posedge clk_in);
      reset_in <= 1'b0;
      t_reset_map();
      t_irq();
      t_registers();
      t_wake_gating();
      t_frame();
      t_soft_reset();
      summarize();
   end
endmodule
